// ==== hw/flash_status_regs.vh ====
// opcodes, status bit positions and reset values of the status and write-enable logic
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH

`define OP_STATUS_WRITE 8'h01
`define OP_STATUS_READ 8'h05
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define OP_SUSPEND_A 8'h75
`define OP_SUSPEND_B 8'hb0
`define OP_RESUME_A 8'h7a
`define OP_RESUME_B 8'h30
`define OP_ARRAY_ERASE_A 8'hc7
`define OP_ARRAY_ERASE_B 8'h60
`define OP_VOL_PARAM_WRITE 8'hc0
`define OP_VOL_BANK_WRITE 8'h17

`define SR_LOCK 7
`define SR_QUAD 6
`define SR_BP_HI 5
`define SR_BP_LO 2
`define SR_WEL 1
`define SR_WIP 0
`define SR_RESET 8'h00
`define BP_NONE 4'h0

`define BIT_LAST 3'h7
`define BYTE_OPCODE 2'h1
`define BYTE_DATA 2'h2
`define BYTE_ZERO 2'h0
`define BIT_ZERO 3'h0
`define OPCODE_ZERO 8'h00

// sync reset image {hold_reset_n, write_protect_n, si, cs_n, sck}: pins idle
`define SYNC_RST 5'h1a

`endif

// ==== hw/pin_sync.v ====
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module pin_sync (
	input wire core_clk,
	input wire rst_n,
	input wire [4:0] d,
	output reg [4:0] q
);
`include "flash_status_regs.vh"

reg [4:0] meta_r;

always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		meta_r <= `SYNC_RST;
		q <= `SYNC_RST;
	end else begin
		meta_r <= d;
		q <= meta_r;
	end
end

endmodule

// ==== hw/flash_status_logic.v ====
// status register and write-enable gating of a serial flash, spi mode 0
`timescale 1ns/1ps
module flash_status_logic (
	input wire core_clk,
	input wire arst_n,
	input wire sck,
	input wire cs_n,
	input wire si,
	input wire write_protect_pin_n,
	input wire hold_reset_pin_n,
	input wire op_done,
	output reg so,
	output reg so_oe,
	output reg op_start,
	output reg [7:0] op_code,
	output reg [7:0] op_data,
	output reg op_abort,
	output reg suspend_req,
	output reg resume_req,
	output reg [7:0] status_word,
	output reg quad_mode
);
`include "flash_status_regs.vh"

// commands that must find the latch set
function needs_latch;
	input [7:0] op;
	begin
		case (op)
		8'h02, 8'h12, 8'h32, 8'h38,
		8'h34, 8'h3e,
		8'hd7, 8'h20, 8'h21,
		8'h52, 8'h5c,
		8'hd8, 8'hdc,
		8'hc7, 8'h60,
		8'h01, 8'h42,
		8'h65, 8'h63,
		8'h85, 8'h83,
		8'h64, 8'h62,
		8'h18, 8'hc5,
		8'hfb, 8'he1,
		8'hfd, 8'he3, 8'he4,
		8'h2f, 8'ha6, 8'h91,
		8'h7e, 8'h98,
		8'he8,
		8'h43, 8'h4a, 8'hb5: needs_latch = 1'b1;
		default: needs_latch = 1'b0;
		endcase
	end
endfunction

// volatile writes finish at once and leave the busy flag alone
function is_volatile;
	input [7:0] op;
	begin
		case (op)
		8'h63, 8'h83, 8'hc5,
		8'hfb, 8'he1, 8'h4a: is_volatile = 1'b1;
		default: is_volatile = 1'b0;
		endcase
	end
endfunction

// program and erase, the only cycles that can be suspended
function is_prog_erase;
	input [7:0] op;
	begin
		case (op)
		8'h02, 8'h12, 8'h32, 8'h38,
		8'h34, 8'h3e,
		8'hd7, 8'h20, 8'h21,
		8'h52, 8'h5c,
		8'hd8, 8'hdc,
		8'hc7, 8'h60: is_prog_erase = 1'b1;
		default: is_prog_erase = 1'b0;
		endcase
	end
endfunction

function is_suspend;
	input [7:0] op;
	begin
		is_suspend = (op == `OP_SUSPEND_A) || (op == `OP_SUSPEND_B);
	end
endfunction

function is_resume;
	input [7:0] op;
	begin
		is_resume = (op == `OP_RESUME_A) || (op == `OP_RESUME_B);
	end
endfunction

function is_array_erase;
	input [7:0] op;
	begin
		is_array_erase = (op == `OP_ARRAY_ERASE_A) || (op == `OP_ARRAY_ERASE_B);
	end
endfunction

reg rst_meta_r;
reg rst_n_r;

always @(posedge core_clk or negedge arst_n) begin
	if (!arst_n) begin
		rst_meta_r <= 1'b0;
		rst_n_r <= 1'b0;
	end else begin
		rst_meta_r <= 1'b1;
		rst_n_r <= rst_meta_r;
	end
end

wire [4:0] pins_s;

pin_sync u_pin_sync (
	.core_clk(core_clk),
	.rst_n(rst_n_r),
	.d({hold_reset_pin_n, write_protect_pin_n, si, cs_n, sck}),
	.q(pins_s)
);

wire sck_s = pins_s[0];
wire cs_s = pins_s[1];
wire si_s = pins_s[2];
wire wp_s = pins_s[3];
wire hold_s = pins_s[4];

reg sck_d_r;
reg cs_d_r;
reg [7:0] shift_r;
reg [2:0] bit_cnt_r;
reg [1:0] byte_cnt_r;
reg [7:0] opcode_r;
reg [7:0] data_r;
reg [7:0] snap_r;
reg wip_r;
reg wel_r;
reg [3:0] bp_r;
reg qe_r;
reg lock_r;
reg pe_busy_r;
reg susp_r;
reg rst_en_r;

wire sck_rise = sck_s & ~sck_d_r & ~cs_s;
wire sck_fall = ~sck_s & sck_d_r & ~cs_s;
wire frame_end = cs_s & ~cs_d_r;
wire [7:0] byte_in = {shift_r[6:0], si_s};
wire [7:0] sr_now = {lock_r, qe_r, bp_r, wel_r, wip_r};
wire reading = (opcode_r == `OP_STATUS_READ) && (byte_cnt_r != `BYTE_ZERO);
wire whole = (bit_cnt_r == `BIT_ZERO);
// protect and hold pins only keep control roles while quad is off
wire sr_locked = lock_r & ~wp_s & ~qe_r;
wire hw_reset = ~hold_s & ~qe_r;
wire exec_frame = frame_end && (byte_cnt_r != `BYTE_ZERO) && whole;

// serial shifter: opcode then first data byte, later bytes only counted
always @(posedge core_clk or negedge rst_n_r) begin
	if (!rst_n_r) begin
		sck_d_r <= 1'b0;
		cs_d_r <= 1'b1;
		shift_r <= `OPCODE_ZERO;
		bit_cnt_r <= `BIT_ZERO;
		byte_cnt_r <= `BYTE_ZERO;
		opcode_r <= `OPCODE_ZERO;
		data_r <= `OPCODE_ZERO;
	end else begin
		sck_d_r <= sck_s;
		cs_d_r <= cs_s;
		if (cs_s) begin
			bit_cnt_r <= `BIT_ZERO;
			if (!frame_end) begin
				byte_cnt_r <= `BYTE_ZERO;
			end
		end else if (sck_rise) begin
			shift_r <= byte_in;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == `BIT_LAST) begin
				if (byte_cnt_r == `BYTE_ZERO) begin
					opcode_r <= byte_in;
				end else if (byte_cnt_r == `BYTE_OPCODE) begin
					data_r <= byte_in;
				end
				if (byte_cnt_r != `BYTE_DATA + 2'h1) begin
					byte_cnt_r <= byte_cnt_r + 2'h1;
				end
			end
		end
	end
end

// status read out: fresh snapshot each byte, no tearing inside a byte
always @(posedge core_clk or negedge rst_n_r) begin
	if (!rst_n_r) begin
		so <= 1'b0;
		so_oe <= 1'b0;
		snap_r <= `SR_RESET;
	end else if (cs_s) begin
		so_oe <= 1'b0;
		so <= 1'b0;
	end else if (sck_fall && reading) begin
		so_oe <= 1'b1;
		if (whole) begin
			snap_r <= sr_now;
			so <= sr_now[`BIT_LAST];
		end else begin
			so <= snap_r[`BIT_LAST - bit_cnt_r];
		end
	end
end

// command execution at the close of each frame
always @(posedge core_clk or negedge rst_n_r) begin
	if (!rst_n_r) begin
		wip_r <= 1'b0;
		wel_r <= 1'b0;
		bp_r <= `BP_NONE;
		qe_r <= 1'b0;
		lock_r <= 1'b0;
		pe_busy_r <= 1'b0;
		susp_r <= 1'b0;
		rst_en_r <= 1'b0;
		op_start <= 1'b0;
		op_code <= `OPCODE_ZERO;
		op_data <= `OPCODE_ZERO;
		op_abort <= 1'b0;
		suspend_req <= 1'b0;
		resume_req <= 1'b0;
	end else begin
		op_start <= 1'b0;
		op_abort <= 1'b0;
		suspend_req <= 1'b0;
		resume_req <= 1'b0;
		if (wip_r && op_done) begin
			wip_r <= 1'b0;
			wel_r <= 1'b0;
			pe_busy_r <= 1'b0;
		end
		if (hw_reset) begin
			// reset aborts any cycle; protection bits survive it
			wip_r <= 1'b0;
			wel_r <= 1'b0;
			pe_busy_r <= 1'b0;
			susp_r <= 1'b0;
			rst_en_r <= 1'b0;
			op_abort <= 1'b1;
		end else if (exec_frame) begin
			rst_en_r <= (opcode_r == `OP_RESET_ENABLE);
			if (opcode_r == `OP_STATUS_READ || opcode_r == `OP_RESET_ENABLE) begin
				// taken even while busy
			end else if (opcode_r == `OP_RESET) begin
				if (rst_en_r) begin
					wip_r <= 1'b0;
					wel_r <= 1'b0;
					pe_busy_r <= 1'b0;
					susp_r <= 1'b0;
					op_abort <= 1'b1;
				end
			end else if (wip_r) begin
				if (is_suspend(opcode_r) && pe_busy_r) begin
					suspend_req <= 1'b1;
					wip_r <= 1'b0;
					susp_r <= 1'b1;
				end
				// anything else is dropped while busy
			end else if (is_resume(opcode_r)) begin
				if (susp_r) begin
					resume_req <= 1'b1;
					wip_r <= 1'b1;
					pe_busy_r <= 1'b1;
					susp_r <= 1'b0;
				end
			end else if (opcode_r == `OP_WRITE_ENABLE) begin
				wel_r <= 1'b1;
			end else if (opcode_r == `OP_WRITE_DISABLE) begin
				wel_r <= 1'b0;
			end else if (opcode_r == `OP_VOL_PARAM_WRITE ||
				opcode_r == `OP_VOL_BANK_WRITE) begin
				op_start <= 1'b1;
				op_code <= opcode_r;
				op_data <= data_r;
			end else if (needs_latch(opcode_r) && wel_r) begin
				if (opcode_r == `OP_STATUS_WRITE) begin
					// latch untouched here, later cleared by completion or a reset; write disable is dropped while the write is busy
					if (!sr_locked && byte_cnt_r == `BYTE_DATA) begin
						lock_r <= data_r[`SR_LOCK];
						qe_r <= data_r[`SR_QUAD];
						bp_r <= data_r[`SR_BP_HI:`SR_BP_LO];
						wip_r <= 1'b1;
						op_start <= 1'b1;
						op_code <= opcode_r;
						op_data <= data_r;
					end
				end else if (is_array_erase(opcode_r) && bp_r != `BP_NONE) begin
					// whole-array erase refused under any protection
				end else begin
					op_start <= 1'b1;
					op_code <= opcode_r;
					op_data <= data_r;
					if (!is_volatile(opcode_r)) begin
						wip_r <= 1'b1;
						pe_busy_r <= is_prog_erase(opcode_r);
					end
				end
			end
		end
	end
end

always @(posedge core_clk or negedge rst_n_r) begin
	if (!rst_n_r) begin
		status_word <= `SR_RESET;
		quad_mode <= 1'b0;
	end else begin
		status_word <= sr_now;
		quad_mode <= qe_r;
	end
end

endmodule

// ==== tb/flash_status_logic_props.sv ====
// checker for the status and write-enable logic
`timescale 1ns/1ps
`include "flash_status_regs.vh"
module flash_status_logic_props (
	input wire core_clk,
	input wire arst_n,
	input wire write_protect_pin_n,
	input wire op_done,
	input wire op_start,
	input wire [7:0] op_code,
	input wire [7:0] op_data,
	input wire op_abort,
	input wire suspend_req,
	input wire [7:0] status_word,
	input wire quad_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_sw;
		op_start && op_code == `OP_STATUS_WRITE;
	endsequence
	sequence s_end;
		op_done && status_word[`SR_WIP];
	endsequence
	a_sw_fields_load: assert property (s_sw |-> ##[1:3] status_word[7:2] == op_data[7:2])
		else $error("status write fields not loaded");
	a_sw_busy_latch: assert property (s_sw |-> ##[1:3] status_word[1:0] == 2'b11)
		else $error("status write busy or latch wrong");
	a_end_clears: assert property (s_end |-> ##[1:3] status_word[1:0] == 2'b00)
		else $error("completion left busy or latch set");
	a_sw_lock_guard: assert property (s_sw |-> !status_word[7] || write_protect_pin_n || quad_mode)
		else $error("locked status write accepted");
	a_erase_bp_guard: assert property (op_start && op_code inside {8'hc7, 8'h60}
		|-> status_word[5:2] == `BP_NONE)
		else $error("chip erase accepted while protected");
	a_start_not_busy: assert property (op_start |-> !status_word[`SR_WIP])
		else $error("command accepted while busy");
	a_gated_needs_wel: assert property (op_start
		&& op_code inside {8'h01, 8'h02, 8'hd8, 8'h42, 8'h4a, 8'hb5}
		|-> status_word[`SR_WEL])
		else $error("gated command accepted without latch");
	a_suspend_busy: assert property (suspend_req |-> status_word[`SR_WIP])
		else $error("suspend outside a busy cycle");
	a_vol_no_busy: assert property (op_start && op_code == `OP_VOL_PARAM_WRITE
		|-> ##[1:3] !status_word[`SR_WIP])
		else $error("volatile write set busy");
	a_quad_follow: assert property ($rose(status_word[`SR_QUAD]) |-> ##[0:1] quad_mode)
		else $error("quad mode not following status");
	a_abort_clear: assert property (op_abort |-> ##[1:3] status_word[1:0] == 2'b00)
		else $error("reset left busy or latch set");
endmodule
bind flash_status_logic flash_status_logic_props i_props (.core_clk, .arst_n,
	.write_protect_pin_n, .op_done, .op_start, .op_code, .op_data, .op_abort,
	.suspend_req, .status_word, .quad_mode);

// ==== tb/spi_host.sv ====
// serial host model: mode 0 frames, clock still between frames
`timescale 1ns/1ps
module spi_host (
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire so
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// msb first, data set while clock low, read data taken on the rise
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			si = b[i];
			#24 sck = 1'b1;
			r[i] = so;
			#24 sck = 1'b0;
		end
	endtask
	task automatic start();
		cs_n = 1'b0;
		#30;
	endtask
	// gap well over eight core cycles; si flips so stale data never looks valid
	task automatic stop();
		#30 cs_n = 1'b1;
		si = ~si;
		#80;
	endtask
endmodule

// ==== tb/test_flash_status_logic.sv ====
// bench for the status and write-enable logic
`timescale 1ns/1ps
`include "flash_status_regs.vh"
module test_flash_status_logic;
	logic core_clk, arst_n, sck, cs_n, si, write_protect_pin_n, hold_reset_pin_n, op_done;
	logic so, so_oe, op_start, op_abort, suspend_req, resume_req, quad_mode;
	logic [7:0] op_code, op_data, status_word, s0;
	logic [7:0] starts = 8'h00, susp = 8'h00, resumes = 8'h00, aborts = 8'h00;
	int error_cnt, comparisons, cycles;
	flash_status_logic i_dut (.core_clk, .arst_n, .sck, .cs_n, .si, .write_protect_pin_n,
		.hold_reset_pin_n, .op_done, .so, .so_oe, .op_start, .op_code, .op_data, .op_abort,
		.suspend_req, .resume_req, .status_word, .quad_mode);
	spi_host i_host (.sck, .cs_n, .si, .so);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// run is about 10000 cycles; ceiling leaves ample margin
	always @(posedge core_clk) begin
		cycles++;
		if (op_start === 1'b1)
			starts++;
		if (suspend_req === 1'b1)
			susp++;
		if (resume_req === 1'b1)
			resumes++;
		if (op_abort === 1'b1)
			aborts++;
		if (cycles == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input bit two);
		logic [7:0] r;
		i_host.start();
		i_host.xfer(op, r);
		if (two)
			i_host.xfer(d, r);
		i_host.stop();
	endtask
	// two status bytes in one frame must both match
	task automatic rd(input logic [7:0] exp);
		logic [7:0] r;
		i_host.start();
		i_host.xfer(`OP_STATUS_READ, r);
		i_host.xfer(8'h00, r);
		chk("status", exp, r);
		chk("drive", 8'h01, {7'h00, so_oe});
		i_host.xfer(8'h00, r);
		chk("status repeat", exp, r);
		i_host.stop();
		chk("drive off", 8'h00, {7'h00, so_oe});
	endtask
	task automatic done_pulse();
		@(negedge core_clk) op_done = 1'b1;
		@(negedge core_clk) op_done = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask
	initial begin
		arst_n = 1'b0;
		write_protect_pin_n = 1'b1;
		hold_reset_pin_n = 1'b1;
		op_done = 1'b0;
		repeat (16) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (10) @(negedge core_clk);
		rd(8'h00);
		cmd(`OP_STATUS_WRITE, 8'h3c, 1);
		rd(8'h00);
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		rd(8'h02);
		cmd(`OP_WRITE_DISABLE, 8'h00, 0);
		rd(8'h00);
		$display("latch test done");
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(`OP_STATUS_WRITE, 8'h3c, 1);
		rd(8'h3f);
		cmd(`OP_WRITE_DISABLE, 8'h00, 0);
		rd(8'h3f);
		done_pulse();
		rd(8'h3c);
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		s0 = starts;
		cmd(`OP_ARRAY_ERASE_B, 8'h00, 0);
		chk("erase starts", s0, starts);
		rd(8'h3e);
		$display("status write test done");
		cmd(`OP_STATUS_WRITE, 8'h80, 1);
		rd(8'h83);
		done_pulse();
		write_protect_pin_n = 1'b0;
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(`OP_STATUS_WRITE, 8'h00, 1);
		rd(8'h82);
		write_protect_pin_n = 1'b1;
		cmd(`OP_STATUS_WRITE, 8'h00, 1);
		rd(8'h03);
		done_pulse();
		$display("lock test done");
		s0 = starts;
		cmd(`OP_VOL_PARAM_WRITE, 8'h11, 1);
		chk("vol starts", s0 + 8'h01, starts);
		chk("vol code", `OP_VOL_PARAM_WRITE, op_code);
		rd(8'h00);
		$display("volatile test done");
		s0 = starts;
		cmd(8'h42, 8'h5a, 1);
		chk("gated starts", s0, starts);
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(8'h42, 8'h5a, 1);
		chk("func code", 8'h42, op_code);
		chk("func data", 8'h5a, op_data);
		rd(8'h03);
		done_pulse();
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(8'h4a, 8'h00, 1);
		chk("pattern code", 8'h4a, op_code);
		rd(8'h02);
		cmd(`OP_WRITE_DISABLE, 8'h00, 0);
		$display("register write test done");
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(8'h02, 8'h00, 1);
		rd(8'h03);
		s0 = susp;
		cmd(`OP_SUSPEND_A, 8'h00, 0);
		chk("suspends", s0 + 8'h01, susp);
		rd(8'h02);
		s0 = resumes;
		cmd(`OP_RESUME_A, 8'h00, 0);
		chk("resumes", s0 + 8'h01, resumes);
		rd(8'h03);
		@(negedge core_clk) hold_reset_pin_n = 1'b0;
		repeat (6) @(negedge core_clk);
		hold_reset_pin_n = 1'b1;
		repeat (6) @(negedge core_clk);
		rd(8'h00);
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(8'h02, 8'h00, 1);
		s0 = aborts;
		cmd(`OP_RESET, 8'h00, 0);
		chk("lone reset", s0, aborts);
		rd(8'h03);
		cmd(`OP_RESET_ENABLE, 8'h00, 0);
		cmd(`OP_RESET, 8'h00, 0);
		chk("soft reset", s0 + 8'h01, aborts);
		rd(8'h00);
		$display("suspend test done");
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(`OP_STATUS_WRITE, 8'h40, 1);
		done_pulse();
		chk("quad", 8'h01, {7'h00, quad_mode});
		cmd(`OP_WRITE_ENABLE, 8'h00, 0);
		cmd(`OP_ARRAY_ERASE_A, 8'h00, 0);
		rd(8'h43);
		done_pulse();
		rd(8'h40);
		$display("quad test done");
		conclude();
	end
endmodule
